// ---- bench/stop_wake_control_assertions.sv ----
// Port checker of the stop-mode wake controller
`timescale 1ns/1ps
module stop_wake_control_assertions (
  input wire logic ref_clk,
  input wire logic reset,
  input wire stop_wake_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic stop_enter,
  input wire logic in_stop,
  input wire logic recovery_reset,
  input wire logic core_clk_en,
  input wire logic timer_interrupt_clk_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_leave;
    $fell(in_stop);
  endsequence
  sequence s_dly;
    $rose(recovery_reset);
  endsequence
  // A true prescaler pulse, not the drop when the divider is first switched on
  sequence s_tpulse;
    $rose(timer_interrupt_clk_en) ##1 !timer_interrupt_clk_en;
  endsequence
  AST_RVALID:
  assert property (req.re |=> rvalid) else $error("no read answer");
  AST_FLAG_ONLY:
  assert property (rvalid && $past(req.bank) == 4'hf && $past(req.addr) == 8'h0b
    |-> rdata[6:0] == 7'h00) else $error("write-only bits read back");
  AST_ENTER:
  assert property (!in_stop && !recovery_reset && stop_enter |=> in_stop) else $error("no stop");
  AST_LEAVE:
  assert property (s_leave |-> recovery_reset) else $error("no delay after wake");
  AST_DIV_OFF:
  assert property (s_leave |-> timer_interrupt_clk_en [*8]) else $error("div kept");
  AST_DIV_GAP:
  assert property (s_tpulse |-> (!timer_interrupt_clk_en || recovery_reset) [*8])
    else $error("prescale gap short");
  AST_CORE_HALT:
  assert property (in_stop |-> !core_clk_en) else $error("core clock in stop");
  AST_DLY_MIN:
  assert property (s_dly |-> recovery_reset [*8]) else $error("delay short");
  AST_DLY_MAX:
  assert property (s_dly |-> ##[1:40] !recovery_reset) else $error("delay long");
endmodule

bind stop_wake_control stop_wake_control_assertions u_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .req(req),
  .rdata(rdata),
  .rvalid(rvalid),
  .stop_enter(stop_enter),
  .in_stop(in_stop),
  .recovery_reset(recovery_reset),
  .core_clk_en(core_clk_en),
  .timer_interrupt_clk_en(timer_interrupt_clk_en)
);

// ---- bench/stop_wake_control_bench.sv ----
// Self-checking bench of the stop-mode wake controller
`timescale 1ns/1ps
`include "stop_wake_regs.svh"
module stop_wake_control_bench;
  localparam int LONG_DLY = 8;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  stop_wake_pkg::reg_req_s req = '0;
  stop_wake_pkg::port_bits_s pins;
  stop_wake_pkg::port_bits_s is_output = '0;
  logic stop_enter = 1'b0;
  logic [23:0] pv = 24'h000000;
  logic [7:0] rdata;
  logic rvalid, in_stop, recovery_reset, core_clk_en, timer_clk_en, shared_irq, wake_async;
  int fails = 0;
  int checked = 0;
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  wake_pins_model u_pins (.drive(pv), .pins(pins));
  stop_wake_control #(.DELAY_LONG_CYCLES(LONG_DLY)) u_dut (.ref_clk(ref_clk), .reset(reset),
    .req(req), .rdata(rdata), .rvalid(rvalid), .pins(pins), .is_output(is_output),
    .stop_enter(stop_enter), .in_stop(in_stop), .recovery_reset(recovery_reset),
    .core_clk_en(core_clk_en), .timer_interrupt_clk_en(timer_clk_en), .shared_irq(shared_irq),
    .wake_async(wake_async));
  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t bit %b want %b", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t byte %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    req <= '{1'b1, 1'b0, 4'hf, a, d};
    tick(1);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick(1);
    req <= '{1'b0, 1'b1, 4'hf, a, 8'h00};
    tick(1);
    req <= '0;
    #1;
    chk1(rvalid, 1'b1);
    chk8(rdata, e);
  endtask
  task automatic count_en(output int kt, output int kc);
    kt = 0;
    kc = 0;
    repeat (32) begin
      tick(1);
      #1;
      kt += int'(timer_clk_en);
      kc += int'(core_clk_en);
    end
  endtask
  task automatic wake(input logic [7:0] c, s, input logic [23:0] idle, act, out, input logic e);
    int n;
    int kt;
    int kc;
    tick(1);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    pv <= idle;
    is_output <= out;
    wr(8'h0b, c);
    wr(8'h0d, s);
    tick(6);
    stop_enter <= 1'b1;
    tick(1);
    stop_enter <= 1'b0;
    #1;
    chk1(in_stop, 1'b1);
    tick(1);
    pv <= act;
    @(negedge ref_clk);
    chk1(wake_async, e);
    n = 0;
    while (in_stop && n < 30) begin
      tick(1);
      #1;
      n++;
    end
    chk1(in_stop, !e);
    if (e && in_stop) give_verdict();
    if (e) begin
      n = 0;
      while (recovery_reset && n < 40) begin
        tick(1);
        #1;
        n++;
      end
      chk1(recovery_reset, 1'b0);
      if (recovery_reset) give_verdict();
      chk8(8'(n), c[5] ? 8'(LONG_DLY) : 8'(`DELAY_SHORT_CYC));
      count_en(kt, kc);
      chk8(8'(kt), 8'h20);
      chk8(8'(kc), 8'h20);
      rd(8'h0b, 8'h80);
    end else begin
      rd(8'h0b, 8'h00);
    end
    $display("wake case done ctrl %h src %h", c, s);
  endtask
  initial begin
    int kt;
    int kc;
    logic [23:0] ip [4] = '{24'h000f00, 24'h000f08, 24'h000f00, 24'h000008};
    tick(8);
    reset <= 1'b0;
    wr(8'h0b, 8'h80);
    rd(8'h0b, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h0d, 8'h04);
    wr(8'hf7, 8'h00);
    for (int j = 0; j < 4; j++) begin
      if (j == 2) wr(8'hf7, 8'h02);
      pv <= ip[j];
      tick(6);
      #1;
      chk1(shared_irq, j == 1 || j == 2);
    end
    $display("interrupt source test done");
    wr(8'h0b, 8'h01);
    count_en(kt, kc);
    chk8(8'(kt), 8'h02);
    chk8(8'(kc), 8'h02);
    $display("prescaler test done");
    for (int i = 0; i < 8; i++) begin
      wake(8'h00, 8'(i << 2), 24'h0, 24'hffffff, 24'h0, i != 0);
    end
    wake(8'h00, 8'h04, 24'h0, 24'h000f00, 24'h0, 1'b1);
    wake(8'h00, 8'h08, 24'h0, 24'h000f00, 24'h0, 1'b0);
    wake(8'h00, 8'h14, 24'h0, 24'h800000, 24'h0, 1'b1);
    wake(8'h00, 8'h0c, 24'h0, 24'h800000, 24'h0, 1'b0);
    wake(8'h00, 8'h44, 24'hffffff, 24'hfffeff, 24'h0, 1'b1);
    wake(8'h00, 8'h04, 24'h0, 24'h000e00, 24'h000100, 1'b1);
    wake(8'h24, 8'h00, 24'h0, 24'h000f00, 24'h0, 1'b1);
    wake(8'h44, 8'h0c, 24'h00ff00, 24'h00ff02, 24'h0, 1'b1);
    wake(8'h44, 8'h00, 24'hffffff, 24'hfffeff, 24'h0, 1'b1);
    wake(8'h05, 8'h00, 24'h0, 24'h000f00, 24'h0, 1'b1);
    give_verdict();
  end
endmodule

// ---- bench/wake_pins_model.sv ----
// Model of the external port pins that act as wake sources
`timescale 1ns/1ps
module wake_pins_model (
  input wire logic [23:0] drive,
  output stop_wake_pkg::port_bits_s pins
);
  // Skewed off the clock, since real pins are asynchronous
  assign #3 pins = drive;
endmodule

// ---- inc/stop_wake_pkg.sv ----
// Types of the stop-mode wake controller
package stop_wake_pkg;

  typedef enum logic [2:0] {
    src_por_only = 3'b000,
    src_nand_p2_lo = 3'b001,
    src_nand_p2_all = 3'b010,
    src_nor_p3 = 3'b011,
    src_nand_p3 = 3'b100,
    src_nor_p3_p0 = 3'b101,
    src_nand_p3_p0 = 3'b110,
    src_nand_p3_p2 = 3'b111
  } wake_src_e;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p2;
    logic [7:0] p3;
  } port_bits_s;

  typedef struct packed {
    logic we;
    logic re;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_stop = 2'b01,
    st_delay = 2'b10
  } wake_state_e;

  // Table mapping the first register's source field to the gate decode
  typedef wake_src_e src_table_t [8];

endpackage

// ---- inc/stop_wake_regs.svh ----
// Register offsets, field positions and timing counts of the stop-mode wake controller
`ifndef STOP_WAKE_REGS_SVH
`define STOP_WAKE_REGS_SVH

`define BANK_F 4'hf
`define ADDR_STOP_RECOVERY_CONTROL 8'h0b
`define ADDR_STOP_RECOVERY_SOURCE_TWO 8'h0d
`define ADDR_PORT_THREE_MODE 8'hf7

`define SRC_FLAG_BIT 7
`define SRC_LEVEL_BIT 6
`define SRC_DELAY_BIT 5
`define SRC_SEL_LO 2
`define SRC_SEL_HI 4
`define SRC_DIV_BIT 0
`define SRT_LEVEL_BIT 6
`define PORT3_MODE_IRQ_BIT 1

`define CTRL_RESET 8'h00
`define SRT_RESET 8'h00
`define PORT3_MODE_RESET 8'h00

`define PRESCALE_DIV 5'h10

// Reset delay after recovery, in ns and in 50 ns cycles of ref_clk
`define DELAY_SHORT_NS 900
`define DELAY_LONG_NS 25600
`define DELAY_SHORT_CYC ((`DELAY_SHORT_NS + 49) / 50)
`define DELAY_LONG_CYC ((`DELAY_LONG_NS + 49) / 50)

`endif

// ---- src/stop_wake_control.sv ----
// Stop-mode wake controller: recovery registers, wake logic, prescaler, interrupt mux
`timescale 1ns/1ps
`include "stop_wake_regs.svh"
module stop_wake_control #(
  parameter stop_wake_pkg::src_table_t SRC_TABLE = '{
    stop_wake_pkg::src_por_only, stop_wake_pkg::src_nand_p2_lo,
    stop_wake_pkg::src_nand_p2_all, stop_wake_pkg::src_nor_p3,
    stop_wake_pkg::src_nand_p3, stop_wake_pkg::src_nor_p3_p0,
    stop_wake_pkg::src_nand_p3_p0, stop_wake_pkg::src_nand_p3_p2},
  parameter int DELAY_LONG_CYCLES = `DELAY_LONG_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire stop_wake_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire stop_wake_pkg::port_bits_s pins,
  input wire stop_wake_pkg::port_bits_s is_output,
  input wire logic stop_enter,
  output logic in_stop,
  output logic recovery_reset,
  output logic core_clk_en,
  output logic timer_interrupt_clk_en,
  output logic shared_irq,
  output logic wake_async
);
  localparam int SHORT_CYC = `DELAY_SHORT_CYC;
  localparam int CNT_W = 16;

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] srt_r, srt_nxt;
  logic [7:0] port3_mode_r, port3_mode_nxt;
  logic flag_r, flag_nxt;
  stop_wake_pkg::wake_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [3:0] pre_r, pre_nxt;
  logic [7:0] rdata_nxt;
  logic rvalid_nxt;
  logic [2:0] sel_one;
  logic wake_one, wake_two;
  stop_wake_pkg::port_bits_s pins_s1, pins_s2, pins_s3, pins_st, pins_st_nxt;
  logic wake_sync;
  logic recover;
  logic hit_ctrl, hit_srt, hit_port3_mode;

  // Source field decoded through a table, not a fixed mapping
  assign sel_one = 3'(SRC_TABLE[ctrl_r[`SRC_SEL_HI:`SRC_SEL_LO]]);

  // Gates see the raw pins so wake works with the core clock stopped
  wake_gate u_gate_one (
    .sel(sel_one),
    .level_high(ctrl_r[`SRC_LEVEL_BIT]),
    .pins(pins),
    .is_output(is_output),
    .wake(wake_one)
  );

  wake_gate u_gate_two (
    .sel(srt_r[`SRC_SEL_HI:`SRC_SEL_LO]),
    .level_high(srt_r[`SRT_LEVEL_BIT]),
    .pins(pins),
    .is_output(is_output),
    .wake(wake_two)
  );

  assign wake_async = wake_one | wake_two;

  // Clocked copy for the state machine: recompute from agreed pin samples
  logic wake_one_s, wake_two_s;
  wake_gate u_gate_one_s (
    .sel(sel_one),
    .level_high(ctrl_r[`SRC_LEVEL_BIT]),
    .pins(pins_st),
    .is_output(is_output),
    .wake(wake_one_s)
  );

  wake_gate u_gate_two_s (
    .sel(srt_r[`SRC_SEL_HI:`SRC_SEL_LO]),
    .level_high(srt_r[`SRT_LEVEL_BIT]),
    .pins(pins_st),
    .is_output(is_output),
    .wake(wake_two_s)
  );

  assign wake_sync = wake_one_s | wake_two_s;

  // Pin state updates only once second and third stages agree
  always_comb begin
    pins_st_nxt = pins_st;
    if (pins_s2 == pins_s3) begin
      pins_st_nxt = pins_s3;
    end
  end

  assign hit_ctrl = (req.bank == `BANK_F) && (req.addr == `ADDR_STOP_RECOVERY_CONTROL);
  assign hit_srt = (req.bank == `BANK_F) && (req.addr == `ADDR_STOP_RECOVERY_SOURCE_TWO);
  assign hit_port3_mode = (req.addr == `ADDR_PORT_THREE_MODE);
  assign recover = (state_r == stop_wake_pkg::st_stop) && wake_sync;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      stop_wake_pkg::st_run: begin
        if (stop_enter) begin
          state_nxt = stop_wake_pkg::st_stop;
        end
      end
      stop_wake_pkg::st_stop: begin
        if (wake_sync) begin
          state_nxt = stop_wake_pkg::st_delay;
          if (ctrl_r[`SRC_DELAY_BIT]) begin
            cnt_nxt = CNT_W'(DELAY_LONG_CYCLES - 1);
          end else begin
            cnt_nxt = CNT_W'(SHORT_CYC - 1);
          end
        end
      end
      stop_wake_pkg::st_delay: begin
        if (cnt_r == '0) begin
          state_nxt = stop_wake_pkg::st_run;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: state_nxt = stop_wake_pkg::st_run;
    endcase
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    srt_nxt = srt_r;
    port3_mode_nxt = port3_mode_r;
    flag_nxt = flag_r | recover;
    rdata_nxt = rdata;
    rvalid_nxt = 1'b0;
    if (req.we && hit_ctrl) begin
      ctrl_nxt = {1'b0, req.wdata[6:0]};
    end
    if (req.we && hit_srt) begin
      // Reserved bits are held at 0 whatever is written
      srt_nxt = req.wdata & 8'h5c;
    end
    if (req.we && hit_port3_mode) begin
      port3_mode_nxt = req.wdata;
    end
    if (recover) begin
      ctrl_nxt[`SRC_DIV_BIT] = 1'b0;
    end
    if (req.re) begin
      rvalid_nxt = 1'b1;
      // Only the recovery flag reads back; write-only bits read 0
      rdata_nxt = hit_ctrl ? {flag_r, 7'h00} : 8'h00;
    end
  end

  // Prescaler free-runs; enables pulse every 16 cycles when selected
  always_comb begin
    pre_nxt = pre_r + 1'b1;
  end

  always_comb begin
    if (ctrl_r[`SRC_DIV_BIT]) begin
      core_clk_en = (pre_r == 4'(`PRESCALE_DIV - 1)) && (state_r == stop_wake_pkg::st_run);
      timer_interrupt_clk_en = (pre_r == 4'(`PRESCALE_DIV - 1));
    end else begin
      core_clk_en = (state_r == stop_wake_pkg::st_run);
      timer_interrupt_clk_en = 1'b1;
    end
  end

  assign in_stop = (state_r == stop_wake_pkg::st_stop);
  assign recovery_reset = (state_r == stop_wake_pkg::st_delay);
  assign shared_irq = port3_mode_r[`PORT3_MODE_IRQ_BIT] ? wake_sync : pins_st.p3[3];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= `CTRL_RESET;
      srt_r <= `SRT_RESET;
      port3_mode_r <= `PORT3_MODE_RESET;
      flag_r <= 1'b0;
      state_r <= stop_wake_pkg::st_run;
      cnt_r <= '0;
      pre_r <= 4'h0;
      rdata <= 8'h00;
      rvalid <= 1'b0;
      pins_s1 <= '0;
      pins_s2 <= '0;
      pins_s3 <= '0;
      pins_st <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      srt_r <= srt_nxt;
      port3_mode_r <= port3_mode_nxt;
      flag_r <= flag_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      rdata <= rdata_nxt;
      rvalid <= rvalid_nxt;
      pins_s1 <= pins;
      pins_s2 <= pins_s1;
      pins_s3 <= pins_s2;
      pins_st <= pins_st_nxt;
    end
  end
endmodule

// ---- src/wake_gate.sv ----
// Pin-group NAND/NOR gate that builds one wake condition
`timescale 1ns/1ps
module wake_gate (
  input wire logic [2:0] sel,
  input wire logic level_high,
  input wire stop_wake_pkg::port_bits_s pins,
  input wire stop_wake_pkg::port_bits_s is_output,
  output logic wake
);
  logic [7:0] grp_mask_p0;
  logic [7:0] grp_mask_p2;
  logic [7:0] grp_mask_p3;
  logic use_nor;
  logic any_high;
  logic any_low;
  logic gate_out;
  logic [7:0] m0;
  logic [7:0] m2;
  logic [7:0] m3;

  always_comb begin
    grp_mask_p0 = 8'h00;
    grp_mask_p2 = 8'h00;
    grp_mask_p3 = 8'h00;
    use_nor = 1'b0;
    case (stop_wake_pkg::wake_src_e'(sel))
      stop_wake_pkg::src_nand_p2_lo: grp_mask_p2 = 8'h0f;
      stop_wake_pkg::src_nand_p2_all: grp_mask_p2 = 8'hff;
      stop_wake_pkg::src_nor_p3: begin
        grp_mask_p3 = 8'h0e;
        use_nor = 1'b1;
      end
      stop_wake_pkg::src_nand_p3: grp_mask_p3 = 8'h0e;
      stop_wake_pkg::src_nor_p3_p0: begin
        grp_mask_p3 = 8'h0e;
        grp_mask_p0 = 8'h81;
        use_nor = 1'b1;
      end
      stop_wake_pkg::src_nand_p3_p0: begin
        grp_mask_p3 = 8'h0e;
        grp_mask_p0 = 8'h81;
      end
      stop_wake_pkg::src_nand_p3_p2: begin
        grp_mask_p3 = 8'h0e;
        grp_mask_p2 = 8'h07;
      end
      default: grp_mask_p0 = 8'h00;
    endcase
  end

  // Output pins drop out of the gate
  assign m0 = grp_mask_p0 & ~is_output.p0;
  assign m2 = grp_mask_p2 & ~is_output.p2;
  assign m3 = grp_mask_p3 & ~is_output.p3;
  assign any_high = |({m0, m2, m3} & {pins.p0, pins.p2, pins.p3});
  assign any_low = |({m0, m2, m3} & ~{pins.p0, pins.p2, pins.p3});

  // NAND of the active inputs is high when any is low; NOR low when any is high
  always_comb begin
    if (({m0, m2, m3} == 24'h000000) || (sel == 3'h0)) begin
      gate_out = 1'b0;
    end else if (use_nor) begin
      gate_out = ~any_high;
    end else begin
      gate_out = any_low;
    end
  end

  // Level low wakes on gate output low; 0 disables an empty group entirely
  assign wake = ((sel != 3'h0) && ({m0, m2, m3} != 24'h000000)) ?
                (gate_out ^ ~level_high) : 1'b0;
endmodule
